// *** bench/rtc_i2c_slave_register_port_tb.sv ***
// Testbench of the two-wire clock register port, both ends joined.
`timescale 1ns/1ps
`default_nettype none
`include "rtcsp_cfg.svh"

module rtc_i2c_slave_register_port_tb
	import rtcsp_pkg::*;
;
	logic                    clock, link_clock, reset_n;
	logic                    cmd_valid, cmd_read, cmd_rstart, cmd_ready;
	logic [`RTCSP_LEN_W-1:0] cmd_len;
	logic [7:0]              tx_data, rx_data, wr_data;
	logic                    tx_next, rx_valid, done, nack, wr_valid;
	rtcsp_ptr_t              wr_addr;
	int                      n_mismatch, cmp_count;
	logic [7:0]              tx_q[$], rx_q[$];
	logic [11:0]             wr_q[$];

	rtcsp_if bus_if ();

	rtcsp_host i_rtcsp_host (.clock(clock), .reset_n(reset_n),
		.bus(bus_if), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
		.cmd_len(cmd_len), .cmd_rstart(cmd_rstart), .cmd_ready(cmd_ready),
		.tx_data(tx_data), .tx_next(tx_next), .rx_data(rx_data),
		.rx_valid(rx_valid), .done(done), .nack(nack));
	rtcsp_dev i_rtcsp_dev (.link_clock(link_clock), .clock(clock),
		.reset_n(reset_n), .bus(bus_if), .wr_valid(wr_valid),
		.wr_addr(wr_addr), .wr_data(wr_data));
	rtcsp_asserts i_rtcsp_asserts (.link_clock(link_clock),
		.reset_n(reset_n), .h_sda_oe(bus_if.h_sda_oe),
		.d_sda_oe(bus_if.d_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

	// ------------------------------------------------------------
	// Clocks, monitors and write data feed
	// ------------------------------------------------------------
	// Link clock edges land on system clock falling edges; no phase relation
	// is assumed by either end.
	always #4 clock = ~clock;
	always #40 link_clock = ~link_clock;

	// Pulses are read before the edge updates land, so none is missed.
	always @(posedge clock) begin
		if (wr_valid === 1'b1) wr_q.push_back({wr_addr, wr_data});
		if (rx_valid === 1'b1) rx_q.push_back(rx_data);
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk_byte(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: data %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	// Issues one command and waits, bounded, for its completion pulse.
	task automatic run_cmd(input logic rd, input logic [3:0] len,
		input logic rs);
		int n;
		@(posedge clock);
		cmd_valid  <= 1'b1;
		cmd_read   <= rd;
		cmd_len    <= len;
		cmd_rstart <= rs;
		if (tx_q.size() > 0) tx_data <= tx_q.pop_front();
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (cmd_ready !== 1'b1 && n < 100);
		cmd_valid <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 60000) begin
			@(posedge clock);
			n++;
			// A loaded write byte is replaced from the queue at once.
			if (tx_next === 1'b1 && tx_q.size() > 0) begin
				tx_data <= tx_q.pop_front();
			end
		end
		if (n >= 60000) begin
			n_mismatch++;
			$display("Error at %0t: command timed out", $time);
			finish_test();
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clock      = 1'b0;
		link_clock = 1'b0;
		reset_n    = 1'b0;
		cmd_valid  = 1'b0;
		cmd_read   = 1'b0;
		cmd_len    = 4'h0;
		cmd_rstart = 1'b0;
		tx_data    = 8'h00;
		n_mismatch = 0;
		cmp_count  = 0;
		// Two link edges see it low; the link side applies it on the third.
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		repeat (40) @(posedge clock);

		// Pointer byte with upper bits set, then a write across the top.
		tx_q = '{8'h1F, 8'hA5, 8'h3C};
		run_cmd(1'b0, 4'h3, 1'b0);
		chk_flag(nack, 1'b0);
		chk_flag(wr_q.size() == 2, 1'b1);
		chk_byte(wr_q[0], 12'hFA5);
		chk_byte(wr_q[1], 12'h03C);
		$display("Test burst write complete");

		// Pointer only, bus kept for a repeated START.
		wr_q.delete();
		tx_q = '{8'h0F};
		run_cmd(1'b0, 4'h1, 1'b1);
		chk_flag(nack, 1'b0);
		chk_flag(wr_q.size() == 0, 1'b1);
		$display("Test pointer set complete");

		// Read two bytes from the stored pointer, wrapping to zero.
		run_cmd(1'b1, 4'h2, 1'b0);
		chk_flag(nack, 1'b0);
		chk_flag(rx_q.size() == 2, 1'b1);
		chk_byte({4'h0, rx_q[0]}, 12'h0A5);
		chk_byte({4'h0, rx_q[1]}, 12'h03C);
		$display("Test pointer read complete");
		finish_test();
	end
endmodule

`default_nettype wire

// *** bench/rtcsp_asserts.sv ***
// Wire-level checks of the two-wire clock register port.
`timescale 1ns/1ps
`default_nettype none

module rtcsp_asserts (
	// Link clock and reset
	input wire logic link_clock,
	input wire logic reset_n,
	// Bus signals
	input wire logic h_sda_oe,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_ff, sda_ff, first_ff, rd_ff, nacked_ff;
	logic [3:0] cnt_ff;
	logic [6:0] adr_ff;
	logic       rise, start, stop, data_bit;

	// ------------------------------------------------------------
	// Bus framing tracker
	// ------------------------------------------------------------
	// Edges are seen one link cycle late, two cycles before the device's synchronised view.
	assign rise     = scl & ~scl_ff;
	assign start    = scl & scl_ff & sda_ff & ~sda;
	assign stop     = scl & scl_ff & ~sda_ff & sda;
	assign data_bit = !first_ff && (cnt_ff inside {[4'h1:4'h7]});

	// Counts bit rises per byte and remembers address and direction.
	always_ff @(posedge link_clock) begin
		scl_ff <= scl;
		sda_ff <= sda;
		if (!reset_n || stop || start) begin
			cnt_ff    <= 4'h0;
			first_ff  <= start;
			rd_ff     <= 1'b0;
			nacked_ff <= 1'b0;
			adr_ff    <= 7'h00;
		end else if (rise) begin
			cnt_ff <= (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
			if (first_ff && cnt_ff < 4'h7) adr_ff <= {adr_ff[5:0], sda};
			if (first_ff && cnt_ff == 4'h7) rd_ff <= sda;
			if (cnt_ff == 4'h8) first_ff <= 1'b0;
			if (cnt_ff == 4'h8 && !first_ff && rd_ff && sda) nacked_ff <= 1'b1;
		end
	end

	default clocking cb @(posedge link_clock); endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	// The ack must rise within 100 link cycles of the R/W bit rise and hold for the four cycles after.
	sequence s_ack_drive;
		##[1:100] $rose(d_sda_oe) ##1 d_sda_oe[*4];
	endsequence
	property p_ack_time;
		rise && first_ff && cnt_ff == 4'h7 && adr_ff == 7'h68 |-> s_ack_drive;
	endproperty
	property p_adr_quiet;
		first_ff && cnt_ff < 4'h8 |-> !d_sda_oe;
	endproperty
	property p_adr_ack;
		rise && first_ff && cnt_ff == 4'h8 && adr_ff == 7'h68 |-> d_sda_oe;
	endproperty
	property p_foreign;
		rise && first_ff && cnt_ff == 4'h8 && adr_ff != 7'h68 |-> !d_sda_oe;
	endproperty
	property p_wr_ack;
		rise && !first_ff && !rd_ff && cnt_ff == 4'h8 |-> d_sda_oe;
	endproperty
	property p_wr_bits;
		data_bit && !rd_ff |-> !d_sda_oe;
	endproperty
	// The master's STOP after a nack is not a read bit, hence the gate.
	property p_rd_host_quiet;
		data_bit && rd_ff && !nacked_ff |-> !h_sda_oe;
	endproperty
	property p_nack_rel;
		nacked_ff |-> !d_sda_oe;
	endproperty
	property p_chg_low;
		$changed(d_sda_oe) |-> !scl;
	endproperty

	a_ack_time: assert property (p_ack_time) else $error("late ack");
	a_adr_quiet: assert property (p_adr_quiet) else $error("addr drive");
	a_adr_ack: assert property (p_adr_ack) else $error("no addr ack");
	a_foreign: assert property (p_foreign) else $error("foreign ack");
	a_wr_ack: assert property (p_wr_ack) else $error("no byte ack");
	a_wr_bits: assert property (p_wr_bits) else $error("write drive");
	a_rd_host_quiet: assert property (p_rd_host_quiet)
		else $error("host drives read bit");
	a_nack_rel: assert property (p_nack_rel) else $error("no release");
	a_chg_low: assert property (p_chg_low) else $error("sda in high");
endmodule

`default_nettype wire

// *** design/rtcsp_dev.sv ***
// Device end: two-wire slave giving pointer access to the clock registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtcsp_cfg.svh"

module rtcsp_dev
	import rtcsp_pkg::*;
(
	// Link clock, samples the bus lines
	input  wire logic       link_clock,
	// System clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// Two-wire bus
	rtcsp_if.dev            bus,
	// Register write events, system clock domain
	output logic            wr_valid,
	output rtcsp_ptr_t      wr_addr,
	output logic [7:0]      wr_data
);

	rtcsp_dev_s r, n;
	logic       start_seen;
	logic       stop_seen;
	logic       scl_rise;
	logic       scl_fall;
	logic [7:0] rx_byte;

	// -------------------------------------------------------------------
	// Bus conditions, seen on the synchronised lines
	// -------------------------------------------------------------------
	// Only the second and third sync stages feed these; the first stage
	// is left alone so a metastable sample never reaches the decode.
	assign start_seen = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
	assign stop_seen  = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
	assign scl_rise   = r.scl_s & ~r.scl_d;
	assign scl_fall   = ~r.scl_s & r.scl_d;
	assign rx_byte    = {r.sh[6:0], r.sda_s};

	// -------------------------------------------------------------------
	// Slave state machine on the link clock
	// -------------------------------------------------------------------
	// The data line is only ever changed after a seen clock fall, so it
	// moves while the clock is low and cannot fake a START or STOP.
	always_comb begin
		n = r;
		n.scl_m = bus.scl;
		n.scl_s = r.scl_m;
		n.scl_d = r.scl_s;
		n.sda_m = bus.sda;
		n.sda_s = r.sda_m;
		n.sda_d = r.sda_s;
		n.rst_m = reset_n;
		n.rst_s = r.rst_m;
		n.ev = 1'b0;
		if (!r.rst_s) begin
			n.st = RTCSP_D_IDLE;
			n.after = RTCSP_D_IDLE;
			n.ack_on = 1'b0;
			n.cnt = `RTCSP_BIT_FIRST;
			n.sh = `RTCSP_BYTE_ZERO;
			n.tx = `RTCSP_BYTE_ZERO;
			n.ptr = `RTCSP_PTR_RST;
			n.mem = '0;
			n.sda_o = 1'b0;
			n.sda_oe = 1'b0;
			n.ev_addr = `RTCSP_PTR_RST;
			n.ev_data = `RTCSP_BYTE_ZERO;
		end else if (start_seen) begin
			// Also a repeated START: drop whatever was going on.
			n.st = RTCSP_D_ADDR;
			n.cnt = `RTCSP_BIT_FIRST;
			n.ack_on = 1'b0;
			n.sda_oe = 1'b0;
		end else if (stop_seen) begin
			n.st = RTCSP_D_IDLE;
			n.sda_oe = 1'b0;
		end else begin
			case (r.st)
				RTCSP_D_ADDR, RTCSP_D_PTR, RTCSP_D_WDAT: begin
					if (scl_rise) begin
						n.sh = rx_byte;
						n.cnt = r.cnt + `RTCSP_BIT_STEP;
						if (r.cnt == `RTCSP_BIT_LAST) begin
							n.st = RTCSP_D_ACK;
							n.ack_on = 1'b0;
							if (r.st == RTCSP_D_ADDR) begin
								if (rx_byte[7:1] != `RTCSP_SLAVE_ADDR) begin
									n.st = RTCSP_D_IGN;
								end else if (rx_byte[0] == `RTCSP_DIR_READ) begin
									n.after = RTCSP_D_RDAT;
								end else begin
									n.after = RTCSP_D_PTR;
								end
							end else if (r.st == RTCSP_D_PTR) begin
								n.ptr = rx_byte[`RTCSP_PTR_W-1:0];
								n.after = RTCSP_D_WDAT;
							end else begin
								n.mem[r.ptr] = rx_byte;
								n.ptr = rtcsp_ptr_next(r.ptr);
								n.ev = 1'b1;
								n.ev_addr = r.ptr;
								n.ev_data = rx_byte;
								n.after = RTCSP_D_WDAT;
							end
						end
					end
				end
				RTCSP_D_ACK: begin
					if (scl_fall) begin
						if (!r.ack_on) begin
							n.ack_on = 1'b1;
							n.sda_oe = 1'b1;
						end else begin
							n.ack_on = 1'b0;
							n.sda_oe = 1'b0;
							n.cnt = `RTCSP_BIT_FIRST;
							n.st = r.after;
							if (r.after == RTCSP_D_RDAT) begin
								n.tx = rtcsp_reg_rd(r.mem, r.ptr);
								n.sda_oe = ~n.tx[7];
							end
						end
					end
				end
				RTCSP_D_RDAT: begin
					if (scl_fall) begin
						n.tx = {r.tx[6:0], 1'b0};
						n.sda_oe = ~r.tx[6];
					end else if (scl_rise) begin
						n.cnt = r.cnt + `RTCSP_BIT_STEP;
						if (r.cnt == `RTCSP_BIT_LAST) begin
							n.st = RTCSP_D_RACK;
							n.ack_on = 1'b0;
							n.ptr = rtcsp_ptr_next(r.ptr);
						end
					end
				end
				RTCSP_D_RACK: begin
					if (scl_fall) begin
						if (r.ack_on) begin
							n.tx = rtcsp_reg_rd(r.mem, r.ptr);
							n.sda_oe = ~n.tx[7];
							n.cnt = `RTCSP_BIT_FIRST;
							n.st = RTCSP_D_RDAT;
						end else begin
							n.sda_oe = 1'b0;
						end
					end else if (scl_rise) begin
						if (r.sda_s) begin
							n.st = RTCSP_D_IGN;
							n.sda_oe = 1'b0;
						end else begin
							n.ack_on = 1'b1;
						end
					end
				end
				RTCSP_D_IDLE, RTCSP_D_IGN: begin
					n.sda_oe = 1'b0;
				end
				default: begin
					n.st = RTCSP_D_IDLE;
					n.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clock) begin
		r <= n;
	end

	// -------------------------------------------------------------------
	// Bus drive and event crossing
	// -------------------------------------------------------------------
	// The data output is held low; only its enable moves, as on an
	// open-drain pin. The clock line has no driver here at all.
	assign bus.d_sda_o  = r.sda_o;
	assign bus.d_sda_oe = r.sda_oe;

	rtcsp_evt_cdc u_evt_cdc (
		.src_clock   (link_clock),
		.src_reset_n (r.rst_s),
		.src_pulse   (r.ev),
		.src_addr    (r.ev_addr),
		.src_data    (r.ev_data),
		.dst_clock   (clock),
		.dst_reset_n (reset_n),
		.dst_valid   (wr_valid),
		.dst_addr    (wr_addr),
		.dst_data    (wr_data)
	);

endmodule

`default_nettype wire

// *** design/rtcsp_evt_cdc.sv ***
// Toggle crossing of register write events from the link clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "rtcsp_cfg.svh"

module rtcsp_evt_cdc
	import rtcsp_pkg::*;
(
	// Source side, link clock domain
	input  wire logic       src_clock,
	input  wire logic       src_reset_n,
	input  wire logic       src_pulse,
	input  wire rtcsp_ptr_t src_addr,
	input  wire logic [7:0] src_data,
	// Destination side, system clock domain
	input  wire logic       dst_clock,
	input  wire logic       dst_reset_n,
	output logic            dst_valid,
	output rtcsp_ptr_t      dst_addr,
	output logic [7:0]      dst_data
);

	rtcsp_xsrc_s s_r, s_n;
	rtcsp_xdst_s d_r, d_n;

	// -------------------------------------------------------------------
	// Source: flip a toggle and hold the word until the next event.
	// -------------------------------------------------------------------
	// Events are at least nine serial bits apart, so the held word is
	// long stable before the far side samples it.
	always_comb begin
		s_n = s_r;
		if (!src_reset_n) begin
			s_n.tog = 1'b0;
			s_n.addr = `RTCSP_PTR_RST;
			s_n.data = `RTCSP_BYTE_ZERO;
		end else if (src_pulse) begin
			s_n.tog = ~s_r.tog;
			s_n.addr = src_addr;
			s_n.data = src_data;
		end
	end

	always_ff @(posedge src_clock) begin
		s_r <= s_n;
	end

	// -------------------------------------------------------------------
	// Destination: two-stage sync of the toggle, then edge capture.
	// -------------------------------------------------------------------
	always_comb begin
		d_n = d_r;
		d_n.m = s_r.tog;
		d_n.s = d_r.m;
		d_n.d = d_r.s;
		d_n.valid = 1'b0;
		if (!dst_reset_n) begin
			d_n.addr = `RTCSP_PTR_RST;
			d_n.data = `RTCSP_BYTE_ZERO;
		end else if (d_r.s != d_r.d) begin
			d_n.valid = 1'b1;
			d_n.addr = s_r.addr;
			d_n.data = s_r.data;
		end
	end

	always_ff @(posedge dst_clock) begin
		d_r <= d_n;
	end

	assign dst_valid = d_r.valid;
	assign dst_addr  = d_r.addr;
	assign dst_data  = d_r.data;

endmodule

`default_nettype wire

// *** design/rtcsp_host.sv ***
// Master end: drives the serial clock and runs pointer writes and reads.
`timescale 1ns/1ps
`default_nettype none
`include "rtcsp_cfg.svh"

module rtcsp_host
	import rtcsp_pkg::*;
(
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	// Two-wire bus
	rtcsp_if.host                        bus,
	// Command
	input  wire logic                    cmd_valid,
	input  wire logic                    cmd_read,
	input  wire logic [`RTCSP_LEN_W-1:0] cmd_len,
	input  wire logic                    cmd_rstart,
	output logic                         cmd_ready,
	// Write data
	input  wire logic [7:0]              tx_data,
	output logic                         tx_next,
	// Read data and completion
	output logic [7:0]                   rx_data,
	output logic                         rx_valid,
	output logic                         done,
	output logic                         nack
);

	rtcsp_host_s r, n;
	logic        tick;
	logic        drives_byte;
	logic        last_byte;

	assign tick = (r.qcnt == `RTCSP_QTR_W'(`RTCSP_QTR_CYC - 1));
	// Address byte and write bytes come from here; read bytes do not.
	assign drives_byte = (r.nbyte == `RTCSP_LEN_ZERO) | ~r.rd;
	assign last_byte = (r.nbyte == r.len);

	// -------------------------------------------------------------------
	// Quarter-bit sequencer: data moves one quarter after the clock falls
	// -------------------------------------------------------------------
	always_comb begin
		n = r;
		n.sda_m = bus.sda;
		n.sda_s = r.sda_m;
		n.tx_next = 1'b0;
		n.rx_valid = 1'b0;
		n.done = 1'b0;
		n.qcnt = `RTCSP_QTR_ZERO;
		if (r.st == RTCSP_H_START || r.st == RTCSP_H_BITS ||
			r.st == RTCSP_H_STOP) begin
			n.qcnt = tick ? `RTCSP_QTR_ZERO : r.qcnt + `RTCSP_QTR_STEP;
			if (tick) begin
				n.ph = r.ph + `RTCSP_PH_STEP;
			end
		end
		if (!reset_n) begin
			n.st = RTCSP_H_IDLE;
			n.ph = `RTCSP_PH_0;
			n.bitn = `RTCSP_HBIT_FIRST;
			n.nbyte = `RTCSP_LEN_ZERO;
			n.len = `RTCSP_LEN_ZERO;
			n.rd = 1'b0;
			n.rstart = 1'b0;
			n.ack_seen = 1'b0;
			n.sh = `RTCSP_BYTE_ZERO;
			n.scl_o = 1'b0;
			n.scl_oe = 1'b0;
			n.sda_o = 1'b0;
			n.sda_oe = 1'b0;
			n.cmd_ready = 1'b0;
			n.rx_data = `RTCSP_BYTE_ZERO;
			n.nack = 1'b0;
		end else begin
			case (r.st)
				RTCSP_H_IDLE, RTCSP_H_HOLD: begin
					n.cmd_ready = 1'b1;
					if (cmd_valid && r.cmd_ready) begin
						n.cmd_ready = 1'b0;
						n.rd = cmd_read;
						n.len = cmd_len;
						n.rstart = cmd_rstart;
						n.sh = {`RTCSP_SLAVE_ADDR, cmd_read};
						n.nbyte = `RTCSP_LEN_ZERO;
						n.bitn = `RTCSP_HBIT_FIRST;
						n.ph = `RTCSP_PH_0;
						n.nack = 1'b0;
						n.st = RTCSP_H_START;
					end
				end
				RTCSP_H_START: begin
					// Same sequence from idle or as a repeated START.
					if (tick) begin
						case (r.ph)
							`RTCSP_PH_0: n.sda_oe = 1'b0;
							`RTCSP_PH_1: n.scl_oe = 1'b0;
							`RTCSP_PH_2: n.sda_oe = 1'b1;
							default: begin
								n.scl_oe = 1'b1;
								n.st = RTCSP_H_BITS;
							end
						endcase
					end
				end
				RTCSP_H_BITS: begin
					if (tick) begin
						case (r.ph)
							`RTCSP_PH_0: begin
								if (r.bitn != `RTCSP_HBIT_ACK) begin
									n.sda_oe = drives_byte & ~r.sh[7];
								end else begin
									n.sda_oe = ~drives_byte & ~last_byte;
								end
							end
							`RTCSP_PH_1: n.scl_oe = 1'b0;
							`RTCSP_PH_2: begin
								if (r.bitn != `RTCSP_HBIT_ACK) begin
									n.sh = {r.sh[6:0], r.sda_s};
								end else begin
									n.ack_seen = ~r.sda_s;
								end
							end
							default: begin
								n.scl_oe = 1'b1;
								n.bitn = r.bitn + `RTCSP_HBIT_STEP;
								if (r.bitn == `RTCSP_HBIT_ACK) begin
									n.bitn = `RTCSP_HBIT_FIRST;
									if (!drives_byte) begin
										n.rx_data = r.sh;
										n.rx_valid = 1'b1;
									end
									if (drives_byte && !r.ack_seen) begin
										n.nack = 1'b1;
										n.st = RTCSP_H_STOP;
									end else if (last_byte) begin
										n.done = r.rstart;
										n.st = r.rstart ? RTCSP_H_HOLD :
											RTCSP_H_STOP;
									end else begin
										n.nbyte = r.nbyte + `RTCSP_LEN_STEP;
										if (!r.rd) begin
											n.sh = tx_data;
											n.tx_next = 1'b1;
										end
									end
								end
							end
						endcase
					end
				end
				RTCSP_H_STOP: begin
					if (tick) begin
						case (r.ph)
							`RTCSP_PH_0: n.sda_oe = 1'b1;
							`RTCSP_PH_1: n.scl_oe = 1'b0;
							`RTCSP_PH_2: n.sda_oe = 1'b0;
							default: begin
								n.done = 1'b1;
								n.st = RTCSP_H_IDLE;
							end
						endcase
					end
				end
				default: begin
					n.st = RTCSP_H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		r <= n;
	end

	// -------------------------------------------------------------------
	// Outputs, all straight from the state record
	// -------------------------------------------------------------------
	assign bus.h_scl_o  = r.scl_o;
	assign bus.h_scl_oe = r.scl_oe;
	assign bus.h_sda_o  = r.sda_o;
	assign bus.h_sda_oe = r.sda_oe;
	assign cmd_ready    = r.cmd_ready;
	assign tx_next      = r.tx_next;
	assign rx_data      = r.rx_data;
	assign rx_valid     = r.rx_valid;
	assign done         = r.done;
	assign nack         = r.nack;

endmodule

`default_nettype wire

// *** inc/rtcsp_cfg.svh ***
// Shared constants of the two-wire clock register port.
`ifndef RTCSP_CFG_SVH
`define RTCSP_CFG_SVH

// -----------------------------------------------------------------------
// Address byte
// -----------------------------------------------------------------------
`define RTCSP_SLAVE_ADDR   7'h68
`define RTCSP_DIR_WRITE    1'b0
`define RTCSP_DIR_READ     1'b1

// -----------------------------------------------------------------------
// Register file and framing
// -----------------------------------------------------------------------
`define RTCSP_PTR_W        4
`define RTCSP_NREG         16
`define RTCSP_PTR_RST      4'h0
`define RTCSP_BYTE_ZERO    8'h00
`define RTCSP_BIT_FIRST    3'h0
`define RTCSP_BIT_LAST     3'h7
`define RTCSP_BIT_STEP     3'h1
`define RTCSP_HBIT_FIRST   4'h0
`define RTCSP_HBIT_ACK     4'h8
`define RTCSP_HBIT_STEP    4'h1
`define RTCSP_LEN_W        4
`define RTCSP_LEN_ZERO     4'h0
`define RTCSP_LEN_STEP     4'h1

// -----------------------------------------------------------------------
// Timing of the master's serial clock
// -----------------------------------------------------------------------
`define RTCSP_CLK_PERIOD_NS 8
`define RTCSP_SCL_PERIOD_NS 10000
`define RTCSP_QTR_CYC ((`RTCSP_SCL_PERIOD_NS + 4 * `RTCSP_CLK_PERIOD_NS - 1) \
	/ (4 * `RTCSP_CLK_PERIOD_NS))
`define RTCSP_QTR_W        9
`define RTCSP_QTR_ZERO     9'h000
`define RTCSP_QTR_STEP     9'h001
`define RTCSP_PH_0         2'h0
`define RTCSP_PH_1         2'h1
`define RTCSP_PH_2         2'h2
`define RTCSP_PH_3         2'h3
`define RTCSP_PH_STEP      2'h1

`endif

// *** inc/rtcsp_if.sv ***
// Two-wire bus between the clock register port and its master.
`timescale 1ns/1ps
`default_nettype none

interface rtcsp_if;
	// Master drives: open-drain clock and data.
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	// Device drives: open-drain data only, it never touches the clock.
	logic d_sda_o;
	logic d_sda_oe;
	// Resolved wire levels with pull-ups.
	logic scl;
	logic sda;

	// A line is low whenever any enabled driver drives low.
	assign scl = h_scl_oe ? h_scl_o : 1'b1;
	assign sda = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

	modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
		input scl, sda);
	modport dev (output d_sda_o, d_sda_oe, input scl, sda);
endinterface

`default_nettype wire

// *** inc/rtcsp_pkg.sv ***
// Types and helper functions of the two-wire clock register port.
`include "rtcsp_cfg.svh"

package rtcsp_pkg;

	// -------------------------------------------------------------------
	// Basic types
	// -------------------------------------------------------------------
	typedef logic [`RTCSP_PTR_W-1:0]          rtcsp_ptr_t;
	typedef logic [`RTCSP_NREG-1:0][7:0]      rtcsp_mem_t;

	typedef enum logic [2:0] {
		RTCSP_D_IDLE,
		RTCSP_D_ADDR,
		RTCSP_D_PTR,
		RTCSP_D_WDAT,
		RTCSP_D_ACK,
		RTCSP_D_RDAT,
		RTCSP_D_RACK,
		RTCSP_D_IGN
	} rtcsp_dst_e;

	typedef enum logic [2:0] {
		RTCSP_H_IDLE,
		RTCSP_H_START,
		RTCSP_H_BITS,
		RTCSP_H_STOP,
		RTCSP_H_HOLD
	} rtcsp_hst_e;

	// -------------------------------------------------------------------
	// State records
	// -------------------------------------------------------------------
	typedef struct packed {
		logic       scl_m, scl_s, scl_d;
		logic       sda_m, sda_s, sda_d;
		logic       rst_m, rst_s;
		rtcsp_dst_e st;
		rtcsp_dst_e after;
		logic       ack_on;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		rtcsp_ptr_t ptr;
		rtcsp_mem_t mem;
		logic       sda_o, sda_oe;
		logic       ev;
		rtcsp_ptr_t ev_addr;
		logic [7:0] ev_data;
	} rtcsp_dev_s;

	typedef struct packed {
		logic                   sda_m, sda_s;
		rtcsp_hst_e             st;
		logic [`RTCSP_QTR_W-1:0] qcnt;
		logic [1:0]             ph;
		logic [3:0]             bitn;
		logic [`RTCSP_LEN_W-1:0] nbyte, len;
		logic                   rd, rstart, ack_seen;
		logic [7:0]             sh;
		logic                   scl_o, scl_oe, sda_o, sda_oe;
		logic                   cmd_ready, tx_next, rx_valid, done, nack;
		logic [7:0]             rx_data;
	} rtcsp_host_s;

	typedef struct packed {
		logic       tog;
		rtcsp_ptr_t addr;
		logic [7:0] data;
	} rtcsp_xsrc_s;

	typedef struct packed {
		logic       m, s, d;
		logic       valid;
		rtcsp_ptr_t addr;
		logic [7:0] data;
	} rtcsp_xdst_s;

	// -------------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------------
	// Pointer advance; wraps past the top register to register zero.
	function automatic rtcsp_ptr_t rtcsp_ptr_next(input rtcsp_ptr_t p);
		return p + `RTCSP_PTR_W'(1);
	endfunction

	// Register file read at the pointer.
	function automatic logic [7:0] rtcsp_reg_rd(input rtcsp_mem_t m,
		input rtcsp_ptr_t p);
		return m[p];
	endfunction

endpackage
